// [hdl/io_port_pkg.sv]
// shared constants, register map and carrier types for the i/o port block
package io_port_pkg;

   // ==========================================================
   // geometry
   localparam int PIN_COUNT = 8;
   localparam int DM_WIDTH  = 3;

   // ==========================================================
   // drive mode encodings
   localparam logic [2:0] DM_HIZ_ANALOG  = 3'h0;
   localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
   localparam logic [2:0] DM_RES_PULLUP  = 3'h2;
   localparam logic [2:0] DM_RES_PULLDN  = 3'h3;
   localparam logic [2:0] DM_OD_LOW      = 3'h4;
   localparam logic [2:0] DM_OD_HIGH     = 3'h5;
   localparam logic [2:0] DM_STRONG      = 3'h6;
   localparam logic [2:0] DM_RES_BOTH    = 3'h7;

   // ==========================================================
   // interrupt edge modes
   localparam logic [1:0] EDGE_NONE    = 2'h0;
   localparam logic [1:0] EDGE_RISING  = 2'h1;
   localparam logic [1:0] EDGE_FALLING = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;

   // ==========================================================
   // post-reset pull selection held in nonvolatile storage
   localparam logic [1:0] RST_PULL_NONE = 2'h0;
   localparam logic [1:0] RST_PULL_DOWN = 2'h1;
   localparam logic [1:0] RST_PULL_UP   = 2'h2;

   // ==========================================================
   // threshold reference select for the special pin pair
   localparam logic [1:0] REF_HALF_VDDIO = 2'h0;
   localparam logic [1:0] REF_040_VDDIO  = 2'h1;
   localparam logic [1:0] REF_HALF_VREF  = 2'h2;
   localparam logic [1:0] REF_ANALOG     = 2'h3;

   // ==========================================================
   // register byte offsets
   localparam logic [5:0] OFS_DATA_OUT   = 6'h00;
   localparam logic [5:0] OFS_DRIVE_LO   = 6'h04;
   localparam logic [5:0] OFS_PIN_IN     = 6'h08;
   localparam logic [5:0] OFS_EDGE_MODE  = 6'h0C;
   localparam logic [5:0] OFS_IRQ_STATUS = 6'h10;
   localparam logic [5:0] OFS_IRQ_MASK   = 6'h14;
   localparam logic [5:0] OFS_PAIR_CFG   = 6'h18;
   localparam logic [5:0] OFS_PWR_CTRL   = 6'h1C;
   localparam logic [5:0] OFS_RST_CFG    = 6'h20;
   localparam logic [5:0] OFS_NV_CFG     = 6'h24;
   localparam logic [5:0] OFS_STATE      = 6'h28;

   // ==========================================================
   // reset and read-back values
   localparam logic [31:0] RST_WORD_ZERO = 32'h0000_0000;
   localparam logic [31:0] RD_UNMAPPED   = 32'hDEAD_BEEF;
   localparam logic [1:0]  NV_DEFAULT    = 2'h0;

   // ==========================================================
   // timing: nonvolatile copy takes this many cycles after reset release
   localparam int NV_LOAD_NS     = 16;
   localparam int CLK_PERIOD_NS  = 4;
   localparam int NV_LOAD_CYCLES = (NV_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [5:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } bus_req_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } bus_rsp_type;

   typedef struct packed {
      logic [PIN_COUNT-1:0] out;
      logic [PIN_COUNT-1:0] oe;
      logic [PIN_COUNT-1:0] pull_up;
      logic [PIN_COUNT-1:0] pull_down;
      logic [PIN_COUNT-1:0] analog_hiz;
   } pad_ctrl_type;

endpackage

// [hdl/pin_edge_detect.sv]
// per-pin edge detection for the port interrupt unit
`timescale 1ns/1ns
module pin_edge_detect #(
   parameter int PINS = 8
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // pins and modes
   input  wire logic [PINS-1:0]   pin_level,
   input  wire logic [2*PINS-1:0] edge_mode,
   // events
   output logic      [PINS-1:0]   pin_event
);

   typedef struct packed {
      logic [PINS-1:0] last;
      logic            primed;
   } state_type;

   state_type state;
   state_type next_state;
   logic [PINS-1:0] hit;

   // ==========================================================
   // edge compare, one copy per pin
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         logic rise;
         logic fall;
         logic [1:0] mode;
         assign mode = edge_mode[2*g +: 2];
         assign rise = state.primed & pin_level[g] & ~state.last[g];
         assign fall = state.primed & ~pin_level[g] & state.last[g];
         assign hit[g] = ((mode == io_port_pkg::EDGE_RISING)  & rise) |
                         ((mode == io_port_pkg::EDGE_FALLING) & fall) |
                         ((mode == io_port_pkg::EDGE_BOTH) & (rise | fall));
      end
   endgenerate

   always_comb begin
      next_state        = state;
      next_state.last   = pin_level;
      next_state.primed = 1'b1;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign pin_event = hit;

endmodule

// [hdl/nv_reset_loader.sv]
// copies the nonvolatile per-port reset pull setting at reset release
`timescale 1ns/1ns
module nv_reset_loader #(
   parameter int PINS = 8
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   // nonvolatile store
   input  wire logic [1:0]    nv_pull,
   // loaded result
   output logic      [1:0]    rst_pull,
   output logic               done
);

   typedef struct packed {
      logic [1:0] pull;
      logic [3:0] count;
      logic       done;
   } state_type;

   state_type state;
   state_type next_state;

   always_comb begin
      next_state = state;
      if (!state.done) begin
         if (state.count == 4'(io_port_pkg::NV_LOAD_CYCLES - 1)) begin
            next_state.pull = nv_pull;
            next_state.done = 1'b1;
         end else begin
            next_state.count = state.count + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rst_pull = state.pull;
   assign done     = state.done;

endmodule

// [hdl/io_port_ctrl.sv]
// i/o port controller: reset state, retention, pin interrupts, special pin pair
// What this block does
// - reset forces every pin to analog high-z
// - post-reset pull up or down per port
// - nonvolatile reset setting copied at release
// - pins hold state in low power
// - interrupt detection runs in low power
// - one threshold shared by special pin pair
// - analog global signal selectable as threshold
// - optional hysteresis on special pin input
// - per-pin edge mode rising, falling, both, none
// - event sets status bit and requests interrupt
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
module io_port_ctrl #(
   parameter int PINS = io_port_pkg::PIN_COUNT
) (
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   // avalon-mm slave
   input  wire logic [5:0]                 avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   output logic      [31:0]                avs_readdata,
   output logic                            avs_waitrequest,
   // pads
   input  wire logic [PINS-1:0]            pin_in,
   output logic      [PINS-1:0]            pin_out,
   output logic      [PINS-1:0]            pin_oe,
   output logic      [PINS-1:0]            pin_pull_up,
   output logic      [PINS-1:0]            pin_pull_down,
   output logic      [PINS-1:0]            pin_analog_hiz,
   // special pin pair threshold control
   output logic      [1:0]                 special_io_pin_ref_sel,
   output logic                            special_io_pin_hyst_en,
   // nonvolatile store and power
   input  wire logic [1:0]                 nv_reset_pull,
   input  wire logic                       low_power,
   // interrupt to controller
   output logic                            port_interrupt_unit_irq
);

   typedef struct packed {
      logic [PINS-1:0]   data_out;
      logic [3*PINS-1:0] drive;
      logic [2*PINS-1:0] edge_mode;
      logic [PINS-1:0]   irq_status;
      logic [PINS-1:0]   irq_mask;
      logic [1:0]        ref_sel;
      logic              hyst_en;
      logic              configured;
      logic [1:0]        rst_pull;
      logic              rst_loaded;
      logic [31:0]       readdata;
      logic              waitrequest;
      logic              irq;
      io_port_pkg::pad_ctrl_type pad;
   } state_type;

   state_type state;
   state_type next_state;

   logic [PINS-1:0] pin_event;
   logic [1:0]      loaded_pull;
   logic            load_done;
   logic            access;
   logic [31:0]     rd_word;

   // ==========================================================
   // submodules
   pin_edge_detect #(
      .PINS      (PINS)
   ) u_edge (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .pin_level (pin_in),
      .edge_mode (state.edge_mode),
      .pin_event (pin_event)
   );

   nv_reset_loader #(
      .PINS     (PINS)
   ) u_nv (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .nv_pull  (nv_reset_pull),
      .rst_pull (loaded_pull),
      .done     (load_done)
   );

   // ==========================================================
   // read mux
   always_comb begin
      rd_word = io_port_pkg::RST_WORD_ZERO;
      case (avs_address)
         io_port_pkg::OFS_DATA_OUT:   rd_word[PINS-1:0] = state.data_out;
         io_port_pkg::OFS_DRIVE_LO:   rd_word[3*PINS-1:0] = state.drive;
         io_port_pkg::OFS_PIN_IN:     rd_word[PINS-1:0] = pin_in;
         io_port_pkg::OFS_EDGE_MODE:  rd_word[2*PINS-1:0] = state.edge_mode;
         io_port_pkg::OFS_IRQ_STATUS: rd_word[PINS-1:0] = state.irq_status;
         io_port_pkg::OFS_IRQ_MASK:   rd_word[PINS-1:0] = state.irq_mask;
         io_port_pkg::OFS_PAIR_CFG:   rd_word[2:0] = {state.hyst_en, state.ref_sel};
         io_port_pkg::OFS_PWR_CTRL:   rd_word[0] = low_power;
         io_port_pkg::OFS_RST_CFG:    rd_word[1:0] = state.rst_pull;
         io_port_pkg::OFS_NV_CFG:     rd_word[1:0] = loaded_pull;
         io_port_pkg::OFS_STATE:      rd_word[1:0] = {state.configured, load_done};
         default:                     rd_word = io_port_pkg::RD_UNMAPPED;
      endcase
   end

   assign access = (avs_read | avs_write) & state.waitrequest;

   // ==========================================================
   // next state
   always_comb begin
      next_state             = state;
      next_state.waitrequest = 1'b1;
      // one wait cycle, then answer on the second edge
      if ((avs_read | avs_write) && state.waitrequest) begin
         next_state.waitrequest = 1'b0;
         if (avs_read) begin
            next_state.readdata = rd_word;
         end
      end
      // take the loaded value once, so later software writes are kept
      if (load_done && !state.rst_loaded) begin
         next_state.rst_pull   = loaded_pull;
         next_state.rst_loaded = 1'b1;
      end
      if (access && avs_write) begin
         case (avs_address)
            io_port_pkg::OFS_DATA_OUT: begin
               next_state.data_out = avs_writedata[PINS-1:0];
            end
            io_port_pkg::OFS_DRIVE_LO: begin
               next_state.drive      = avs_writedata[3*PINS-1:0];
               next_state.configured = load_done;
            end
            io_port_pkg::OFS_EDGE_MODE: begin
               next_state.edge_mode = avs_writedata[2*PINS-1:0];
            end
            io_port_pkg::OFS_IRQ_MASK: begin
               next_state.irq_mask = avs_writedata[PINS-1:0];
            end
            io_port_pkg::OFS_PAIR_CFG: begin
               next_state.ref_sel = avs_writedata[1:0];
               next_state.hyst_en = avs_writedata[2];
            end
            io_port_pkg::OFS_RST_CFG: begin
               if (load_done) begin
                  next_state.rst_pull = avs_writedata[1:0];
               end
            end
            default: begin
            end
         endcase
      end
      // write-one-to-clear; a new event wins over the clear
      if (access && avs_write && avs_address == io_port_pkg::OFS_IRQ_STATUS) begin
         next_state.irq_status = state.irq_status & ~avs_writedata[PINS-1:0];
      end
      next_state.irq_status = next_state.irq_status | pin_event;
      next_state.irq = |(next_state.irq_status & next_state.irq_mask);
      // pad drive: analog high-z until nonvolatile copy is done
      next_state.pad = '0;
      if (!load_done) begin
         next_state.pad.analog_hiz = '1;
      end else if (!state.configured) begin
         next_state.pad.analog_hiz = (state.rst_pull == io_port_pkg::RST_PULL_NONE) ?
                                     '1 : '0;
         next_state.pad.pull_up   = (state.rst_pull == io_port_pkg::RST_PULL_UP) ?
                                     '1 : '0;
         next_state.pad.pull_down = (state.rst_pull == io_port_pkg::RST_PULL_DOWN) ?
                                     '1 : '0;
      end else begin
         // drive mode decode; in low power the pad state is held at its previous value below
         for (int i = 0; i < PINS; i++) begin
            case (state.drive[3*i +: 3])
               io_port_pkg::DM_HIZ_ANALOG: next_state.pad.analog_hiz[i] = 1'b1;
               io_port_pkg::DM_HIZ_DIGITAL: begin
               end
               io_port_pkg::DM_RES_PULLUP: begin
                  next_state.pad.oe[i]      = ~state.data_out[i];
                  next_state.pad.pull_up[i] = state.data_out[i];
               end
               io_port_pkg::DM_RES_PULLDN: begin
                  next_state.pad.oe[i]        = state.data_out[i];
                  next_state.pad.pull_down[i] = ~state.data_out[i];
               end
               io_port_pkg::DM_OD_LOW: begin
                  next_state.pad.oe[i] = ~state.data_out[i];
               end
               io_port_pkg::DM_OD_HIGH: next_state.pad.oe[i] = state.data_out[i];
               io_port_pkg::DM_STRONG:  next_state.pad.oe[i] = 1'b1;
               default: begin
                  next_state.pad.pull_up[i]   = state.data_out[i];
                  next_state.pad.pull_down[i] = ~state.data_out[i];
               end
            endcase
            next_state.pad.out[i] = state.data_out[i];
         end
      end
      if (low_power) begin
         next_state.pad = state.pad;
      end
   end

   // ==========================================================
   // registers; reset puts pads into analog high-z
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state                <= '0;
         state.waitrequest    <= 1'b1;
         state.pad.analog_hiz <= '1;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // outputs
   assign avs_readdata            = state.readdata;
   assign avs_waitrequest         = state.waitrequest;
   assign pin_out                 = state.pad.out;
   assign pin_oe                  = state.pad.oe;
   assign pin_pull_up             = state.pad.pull_up;
   assign pin_pull_down           = state.pad.pull_down;
   assign pin_analog_hiz          = state.pad.analog_hiz;
   assign special_io_pin_ref_sel  = state.ref_sel;
   assign special_io_pin_hyst_en  = state.hyst_en;
   assign port_interrupt_unit_irq = state.irq;

   // ==========================================================
   // checks
   AST_RESET_HIZ: assert property (@(posedge sys_clk)
      !rst_n |-> ##1 (pin_analog_hiz == '1 || !rst_n))
      else $error("pins not analog high-z after reset");
   AST_NV_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !load_done |-> ##1 (pin_analog_hiz == '1))
      else $error("pin left high-z before nonvolatile copy");
   AST_PULL_UP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (load_done && !state.configured && !low_power &&
       state.rst_pull == io_port_pkg::RST_PULL_UP) |=> (pin_pull_up == '1))
      else $error("post-reset pull-up not applied");
   AST_COPY: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(load_done) |-> (loaded_pull == $past(nv_reset_pull)))
      else $error("nonvolatile value not copied");
   AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      low_power |=> $stable(pin_oe) && $stable(pin_out) && $stable(pin_analog_hiz))
      else $error("pins changed in low power");
   AST_EVENT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pin_event != '0) |=> ((state.irq_status & $past(pin_event)) == $past(pin_event)))
      else $error("event did not set status");
   AST_LP_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (low_power && (pin_event & state.irq_mask) != '0) |=> port_interrupt_unit_irq)
      else $error("no wake interrupt in low power");
   AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
      port_interrupt_unit_irq |-> ((state.irq_status & state.irq_mask) != '0))
      else $error("irq high without masked status");
   AST_REF: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (access && avs_write && avs_address == io_port_pkg::OFS_PAIR_CFG)
      |=> (special_io_pin_ref_sel == $past(avs_writedata[1:0])))
      else $error("threshold select not taken");
   AST_ANSWER: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((avs_read | avs_write) && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus answer late");

   COV_WAKE:  cover property (@(posedge sys_clk) low_power && port_interrupt_unit_irq);
   COV_CLEAR: cover property (@(posedge sys_clk)
      access && avs_write && avs_address == io_port_pkg::OFS_IRQ_STATUS);
   COV_PULL:  cover property (@(posedge sys_clk) load_done && pin_pull_down != '0);

endmodule

// [dv/pin_partner.sv]
// behavioural model of the board wired to the port pads
`timescale 1ns/1ns
module pin_partner (
   // clock
   input  wire logic       sys_clk,
   // pad controls from the port
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pull_up,
   input  wire logic [7:0] pin_pull_down,
   // board side drivers and resistors
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_pullup,
   // resolved line levels
   output logic      [7:0] pin_in
);
   logic [7:0] float_q = 8'h55;
   // an undriven, unpulled line shows a changing pattern, never a stale level
   always @(posedge sys_clk) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (ext_pullup[i] || pin_pull_up[i]) pin_in[i] = 1'b1;
         else if (pin_pull_down[i]) pin_in[i] = 1'b0;
         else pin_in[i] = float_q[i];
      end
   end
endmodule

// [dv/test_io_port_reset_and_retention.sv]
// self-checking bench for the i/o port controller
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module test_io_port_reset_and_retention;
   // ==========================================================
   // signals
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_analog_hiz;
   logic [1:0]  special_io_pin_ref_sel;
   logic        special_io_pin_hyst_en;
   logic [1:0]  nv_reset_pull = 2'h0;
   logic        low_power = 1'b0;
   logic        port_interrupt_unit_irq;
   logic [7:0]  ext_val = 8'h00;
   logic [7:0]  ext_en = 8'h00;
   logic [7:0]  ext_pullup = 8'h00;
   logic [15:0] seed = 16'h0007;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          cycles = 0;
   // ==========================================================
   // design and board
   always #(io_port_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   io_port_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
      .pin_pull_down(pin_pull_down), .pin_analog_hiz(pin_analog_hiz),
      .special_io_pin_ref_sel(special_io_pin_ref_sel),
      .special_io_pin_hyst_en(special_io_pin_hyst_en), .nv_reset_pull(nv_reset_pull),
      .low_power(low_power), .port_interrupt_unit_irq(port_interrupt_unit_irq));
   pin_partner board (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .ext_val(ext_val),
      .ext_en(ext_en), .ext_pullup(ext_pullup), .pin_in(pin_in));
   // ==========================================================
   // helpers and reference model
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   function automatic logic [7:0] exp_oe(logic [23:0] dm, logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         case (dm[3*i +: 3])
            io_port_pkg::DM_RES_PULLUP, io_port_pkg::DM_OD_LOW: exp_oe[i] = ~d[i];
            io_port_pkg::DM_RES_PULLDN, io_port_pkg::DM_OD_HIGH: exp_oe[i] = d[i];
            io_port_pkg::DM_STRONG: exp_oe[i] = 1'b1;
            default: exp_oe[i] = 1'b0;
         endcase
      end
   endfunction
   function automatic logic [7:0] ev(logic [7:0] p, logic [7:0] c, logic [15:0] m);
      for (int i = 0; i < 8; i++) begin
         case (m[2*i +: 2])
            io_port_pkg::EDGE_RISING: ev[i] = ~p[i] & c[i];
            io_port_pkg::EDGE_FALLING: ev[i] = p[i] & ~c[i];
            io_port_pkg::EDGE_BOTH: ev[i] = p[i] ^ c[i];
            default: ev[i] = 1'b0;
         endcase
      end
   endfunction
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (n >= 50) `CHK(avs_waitrequest, 1'b0)
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, q);
   endtask
   task automatic do_reset(input logic [1:0] p);
      logic [31:0] q;
      int n;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      nv_reset_pull <= p;
      repeat (3) @(posedge sys_clk);
      `CHK(pin_analog_hiz, 8'hFF)
      `CHK(pin_oe, 8'h00)
      rst_n <= 1'b1;
      repeat (io_port_pkg::NV_LOAD_CYCLES) begin
         @(posedge sys_clk);
         `CHK(pin_analog_hiz, 8'hFF)
      end
      n = 0;
      do begin
         rd(io_port_pkg::OFS_STATE, q);
         n++;
      end while (q[0] !== 1'b1 && n < 20);
      repeat (2) @(posedge sys_clk);
      rd(io_port_pkg::OFS_NV_CFG, q);
      `CHK(q[1:0], p)
      `CHK(pin_analog_hiz, (p == io_port_pkg::RST_PULL_NONE) ? 8'hFF : 8'h00)
      `CHK(pin_pull_down, (p == io_port_pkg::RST_PULL_DOWN) ? 8'hFF : 8'h00)
      `CHK(pin_pull_up, (p == io_port_pkg::RST_PULL_UP) ? 8'hFF : 8'h00)
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] q;
      logic [23:0] dm;
      logic [15:0] emode;
      logic [7:0]  d, mask, m_status, m_prev, v, clr;
      for (int p = 0; p < 3; p++) do_reset(p[1:0]);
      wr(io_port_pkg::OFS_RST_CFG, {30'h0, io_port_pkg::RST_PULL_DOWN});
      repeat (3) @(posedge sys_clk);
      `CHK(pin_pull_down, 8'hFF)
      $display("test reset done");
      for (int i = 0; i < 8; i++) dm[3*i +: 3] = i[2:0];
      ext_pullup <= 8'h10;
      d = 8'(rnd());
      for (int k = 0; k < 2; k++) begin
         wr(io_port_pkg::OFS_DATA_OUT, {24'h0, d});
         wr(io_port_pkg::OFS_DRIVE_LO, {8'h0, dm});
         repeat (3) @(posedge sys_clk);
         `CHK(pin_oe, exp_oe(dm, d))
         `CHK(pin_analog_hiz, 8'h01)
         `CHK(pin_out, d)
         rd(io_port_pkg::OFS_PIN_IN, q);
         `CHK(q[4], d[4])
         d = ~d;
      end
      $display("test drive done");
      for (int k = 0; k < 8; k++) begin
         wr(io_port_pkg::OFS_PAIR_CFG, {29'h0, k[2:0]});
         repeat (3) @(posedge sys_clk);
         `CHK(special_io_pin_ref_sel, k[1:0])
         `CHK(special_io_pin_hyst_en, k[2])
      end
      $display("test special pair done");
      ext_en <= 8'hFF;
      ext_val <= 8'h00;
      wr(io_port_pkg::OFS_DRIVE_LO, 32'h0024_9249);
      emode = {rnd() & 16'h00FF} << 8 | 16'h00E4;
      mask = 8'(rnd());
      wr(io_port_pkg::OFS_EDGE_MODE, {16'h0, emode});
      wr(io_port_pkg::OFS_IRQ_MASK, {24'h0, mask});
      wr(io_port_pkg::OFS_IRQ_STATUS, 32'h0000_00FF);
      m_status = 8'h00;
      m_prev = 8'h00;
      for (int k = 0; k < 12; k++) begin
         v = 8'(rnd());
         @(posedge sys_clk);
         ext_val <= v;
         repeat (5) @(posedge sys_clk);
         m_status = m_status | ev(m_prev, v, emode);
         m_prev = v;
         `CHK(port_interrupt_unit_irq, |(m_status & mask))
      end
      rd(io_port_pkg::OFS_IRQ_STATUS, q);
      `CHK(q[7:0], m_status)
      clr = 8'(rnd());
      wr(io_port_pkg::OFS_IRQ_STATUS, {24'h0, clr});
      m_status = m_status & ~clr;
      rd(io_port_pkg::OFS_IRQ_STATUS, q);
      `CHK(q[7:0], m_status)
      rd(6'h3C, q);
      `CHK(q, io_port_pkg::RD_UNMAPPED)
      $display("test interrupts done");
      wr(io_port_pkg::OFS_EDGE_MODE, 32'h0000_FFFF);
      wr(io_port_pkg::OFS_IRQ_MASK, 32'h0000_00FF);
      wr(io_port_pkg::OFS_IRQ_STATUS, 32'h0000_00FF);
      @(posedge sys_clk);
      low_power <= 1'b1;
      repeat (2) @(posedge sys_clk);
      wr(io_port_pkg::OFS_DRIVE_LO, 32'h00DB_6DB6);
      repeat (3) @(posedge sys_clk);
      `CHK(pin_oe, 8'h00)
      rd(io_port_pkg::OFS_PWR_CTRL, q);
      `CHK(q[0], 1'b1)
      @(posedge sys_clk);
      ext_val <= ~m_prev;
      repeat (5) @(posedge sys_clk);
      `CHK(port_interrupt_unit_irq, 1'b1)
      rd(io_port_pkg::OFS_IRQ_STATUS, q);
      `CHK(q[7:0], 8'hFF)
      low_power <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK(pin_oe, 8'hFF)
      do_reset(io_port_pkg::RST_PULL_DOWN);
      $display("test low power done");
      end_of_test();
   end
endmodule
